// file: hdl/fifo_top.sv
`timescale 1ns/100ps
`include "fifo_consts.svh"

// Summary of operation
// - Shift one serial bit per write edge
// - Only complete bit sets update offsets
// - Select low, enable high: nothing shifts
// - Pause loading, write memory, then resume
// - Either control high suspends, keeps bits
// - Almost flags valid after full load
// - Synchronous almost flags on own clock
// - Asynchronous almost flags set/release crosswise
// - Master reset clears pointers, flags, output
// - Master reset before writes; captures timing
// - Partial reset keeps offsets and timing
// - Stopped write clock freezes write flags
// - Stopped read clock freezes read flags
// - Clocks independent or identical
// - Write enable low stores word when not full
// - Full flag low blocks overflow writes
// - Full releases on third write edge after read
// - Read edge presents next word
// - Output enable high sets data_out_oe_n high; data_out stays driven
// - Data words sixteen bits wide
// - Almost empty at or below offset
// - Almost full at depth minus offset
// - Half full set by write, cleared by read
// - Empty releases three read edges after write

module fifo_top (
  input wire logic core_clk,                      // System clock
  input wire logic reset,                         // Async reset, high
  input wire logic write_clk,                     // Writer clock, sampled
  input wire logic read_clk,                      // Reader clock, sampled
  input wire logic write_enable_n,                // Write request
  input wire logic read_enable_n,                 // Read request
  input wire logic offset_load_select_n,          // Offset load select
  input wire logic serial_load_enable_n,          // Serial load enable
  input wire logic serial_in,                     // Serial offset data
  input wire logic flag_timing_select,            // Sync almost flags
  input wire logic full_reset_n,                  // Master reset
  input wire logic partial_reset_n,               // Partial reset
  input wire logic output_enable_n,               // Output enable
  input wire logic [`FIFO_WIDTH-1:0] data_in,     // Write data
  output logic [`FIFO_WIDTH-1:0] data_out,        // Read data
  output logic data_out_oe_n,                     // Low while driving
  output logic empty_flag_n,                      // Empty, low
  output logic full_flag_n,                       // Full, low
  output logic half_full_flag_n,                  // Half full, low
  output logic almost_empty_flag_n,               // Almost empty, low
  output logic almost_full_flag_n                 // Almost full, low
);
  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  wire logic master_rst;
  wire logic ptr_rst;
  assign master_rst = reset | ~full_reset_n;
  assign ptr_rst = master_rst | ~partial_reset_n;

  // ----------------------------------------------------------------
  // Clock edge detection
  // ----------------------------------------------------------------
  logic write_clk_prev;
  logic read_clk_prev;
  wire logic w_edge;
  wire logic r_edge;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      write_clk_prev <= 1'b0;
      read_clk_prev <= 1'b0;
    end else begin
      write_clk_prev <= write_clk;
      read_clk_prev <= read_clk;
    end
  end

  assign w_edge = write_clk & ~write_clk_prev;
  assign r_edge = read_clk & ~read_clk_prev;

  // ----------------------------------------------------------------
  // Configuration captured during master reset
  // ----------------------------------------------------------------
  logic sync_flags;
  logic master_seen;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_flags <= 1'b0;
      master_seen <= 1'b0;
    end else if (!full_reset_n) begin
      sync_flags <= flag_timing_select;
      master_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial offset loading
  // ----------------------------------------------------------------
  fifo_pkg::serial_t shadow;
  logic [`SERIAL_CNT_BITS-1:0] bit_cnt;
  fifo_pkg::offset_t empty_off;
  fifo_pkg::offset_t full_off;
  wire logic shift_bit;
  wire logic load_done;

  assign shift_bit = w_edge & ~offset_load_select_n & ~serial_load_enable_n
                     & write_enable_n & read_enable_n & master_seen;
  assign load_done = shift_bit & (bit_cnt == `SERIAL_LAST);

  // Shadow bits, filled LSB of empty offset first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shadow <= '0;
    end else if (shift_bit) begin
      shadow[bit_cnt] <= serial_in;
    end
  end

  always_ff @(posedge core_clk or posedge master_rst) begin
    if (master_rst) begin
      bit_cnt <= `CNT_RESET;
    end else if (load_done) begin
      bit_cnt <= `CNT_RESET;
    end else if (shift_bit) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // active offsets change only on a full set
  always_ff @(posedge core_clk or posedge master_rst) begin
    if (master_rst) begin
      empty_off <= `OFFSET_DEFAULT;
      full_off <= `OFFSET_DEFAULT;
    end else if (load_done) begin
      empty_off <= shadow[`OFFSET_BITS-1:0];
      full_off <= {serial_in, shadow[`SERIAL_BITS-2:`FULL_OFF_LSB]};
    end
  end

  // Almost flags are frozen while a load is in progress
  wire logic loading;
  assign loading = (bit_cnt != `CNT_RESET);

  // ----------------------------------------------------------------
  // Pointers and views across the two sides
  // ----------------------------------------------------------------
  fifo_pkg::ptr_t wptr;
  fifo_pkg::ptr_t rptr;
  fifo_pkg::ptr_t rptr_w1;
  fifo_pkg::ptr_t rptr_w2;
  fifo_pkg::ptr_t wptr_r1;
  fifo_pkg::ptr_t wptr_r2;
  wire logic do_write;
  wire logic do_read;
  wire fifo_pkg::ptr_t next_wptr;
  wire fifo_pkg::ptr_t next_rptr;

  // store on write edge when not full
  assign do_write = w_edge & ~write_enable_n & full_flag_n & master_seen;
  // read on read edge when not empty
  assign do_read = r_edge & ~read_enable_n & empty_flag_n;
  assign next_wptr = do_write ? fifo_pkg::ptr_t'(wptr + 1'b1) : wptr;
  assign next_rptr = do_read ? fifo_pkg::ptr_t'(rptr + 1'b1) : rptr;

  // Pointer registers
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      wptr <= `PTR_RESET;
      rptr <= `PTR_RESET;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // read pointer through two write stages
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      rptr_w1 <= `PTR_RESET;
      rptr_w2 <= `PTR_RESET;
    end else if (w_edge) begin
      rptr_w1 <= rptr;
      rptr_w2 <= rptr_w1;
    end
  end

  // write pointer through two read stages
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      wptr_r1 <= `PTR_RESET;
      wptr_r2 <= `PTR_RESET;
    end else if (r_edge) begin
      wptr_r1 <= wptr;
      wptr_r2 <= wptr_r1;
    end
  end

  // ----------------------------------------------------------------
  // Word counts as each side sees them
  // ----------------------------------------------------------------
  wire fifo_pkg::ptr_t count_w;
  wire fifo_pkg::ptr_t count_r;
  wire fifo_pkg::ptr_t count_now;
  wire fifo_pkg::ptr_t full_mark;
  wire logic near_full_w;
  wire logic near_empty_r;
  wire logic near_full_now;
  wire logic near_empty_now;

  // Stale far pointer only ever errs toward the safe flag
  assign count_w = fifo_pkg::ptr_t'(next_wptr - rptr_w2);
  assign count_r = fifo_pkg::ptr_t'(wptr_r2 - next_rptr);
  assign count_now = fifo_pkg::ptr_t'(next_wptr - next_rptr);
  assign full_mark = fifo_pkg::ptr_t'(`FIFO_DEPTH - {1'b0, full_off});
  assign near_full_w = (count_w >= full_mark);
  assign near_full_now = (count_now >= full_mark);
  assign near_empty_r = (count_r <= {1'b0, empty_off});
  assign near_empty_now = (count_now <= {1'b0, empty_off});

  // ----------------------------------------------------------------
  // Full and empty flags
  // ----------------------------------------------------------------
  // full only moves on write edges
  // empty only moves on read edges
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      full_flag_n <= 1'b1;
      empty_flag_n <= 1'b0;
    end else begin
      if (w_edge) begin
        full_flag_n <= (count_w != `FIFO_DEPTH);
      end
      if (r_edge) begin
        empty_flag_n <= (count_r != `PTR_RESET);
      end
    end
  end

  // ----------------------------------------------------------------
  // Half-full flag
  // ----------------------------------------------------------------
  // write sets low, read returns high
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      half_full_flag_n <= 1'b1;
    end else if (w_edge && count_now > `FIFO_HALF) begin
      half_full_flag_n <= 1'b0;
    end else if (r_edge && count_now <= `FIFO_HALF) begin
      half_full_flag_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Almost flags, timing chosen at master reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      almost_full_flag_n <= 1'b1;
    end else if (!loading) begin
      if (sync_flags) begin
        if (w_edge) begin
          almost_full_flag_n <= ~near_full_w;
        end
      end else begin
        // set on write, release on read
        if (w_edge && near_full_now) begin
          almost_full_flag_n <= 1'b0;
        end else if (r_edge && !near_full_now) begin
          almost_full_flag_n <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge ptr_rst) begin
    if (ptr_rst) begin
      almost_empty_flag_n <= 1'b0;
    end else if (!loading) begin
      if (sync_flags) begin
        if (r_edge) begin
          almost_empty_flag_n <= ~near_empty_r;
        end
      end else begin
        // set on read, release on write
        if (r_edge && near_empty_now) begin
          almost_empty_flag_n <= 1'b0;
        end else if (w_edge && !near_empty_now) begin
          almost_empty_flag_n <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Array and output register
  // ----------------------------------------------------------------
  fifo_mem_if mem_bus ();

  assign mem_bus.wr_en = do_write;
  assign mem_bus.wr_addr = wptr[`FIFO_ABITS-1:0];
  assign mem_bus.wr_data = data_in;
  assign mem_bus.rd_en = do_read;
  assign mem_bus.rd_addr = rptr[`FIFO_ABITS-1:0];

  fifo_mem u_mem (
    .core_clk (core_clk),
    .clear (ptr_rst),
    .port (mem_bus.mem)
  );

  // Read register lives in the array block; passed out directly
  assign data_out = mem_bus.rd_data;
  assign data_out_oe_n = output_enable_n;
endmodule : fifo_top

// file: include/fifo_consts.svh
`ifndef FIFO_CONSTS_SVH
`define FIFO_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define FIFO_WIDTH 16
`define FIFO_ABITS 12
`define FIFO_PBITS 13
`define FIFO_DEPTH 13'h1000
`define FIFO_HALF 13'h0800

// ----------------------------------------------------------------
// Offset loading
// ----------------------------------------------------------------
`define OFFSET_BITS 12
`define SERIAL_BITS 24
`define SERIAL_LAST 5'h17
`define SERIAL_CNT_BITS 5
`define FULL_OFF_LSB 12
`define OFFSET_DEFAULT 12'h07f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTR_RESET 13'h0000
`define WORD_RESET 16'h0000
`define CNT_RESET 5'h00

`endif

// file: include/fifo_pkg.sv
`include "fifo_consts.svh"

package fifo_pkg;
  typedef logic [`FIFO_WIDTH-1:0] word_t;
  typedef logic [`FIFO_PBITS-1:0] ptr_t;
  typedef logic [`FIFO_ABITS-1:0] addr_t;
  typedef logic [`OFFSET_BITS-1:0] offset_t;
  typedef logic [`SERIAL_BITS-1:0] serial_t;
endpackage : fifo_pkg

// file: include/fifo_mem_if.sv
`timescale 1ns/100ps
`include "fifo_consts.svh"

interface fifo_mem_if;
  logic wr_en;
  fifo_pkg::addr_t wr_addr;
  fifo_pkg::word_t wr_data;
  logic rd_en;
  fifo_pkg::addr_t rd_addr;
  fifo_pkg::word_t rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_en, input rd_addr, output rd_data);
endinterface : fifo_mem_if

// file: hdl/fifo_mem.sv
`timescale 1ns/100ps
`include "fifo_consts.svh"

module fifo_mem (
  input wire logic core_clk, // System clock
  input wire logic clear,    // Async clear of the read register
  fifo_mem_if.mem port       // Array access
);
  fifo_pkg::word_t array [0:`FIFO_DEPTH-1];

  // ----------------------------------------------------------------
  // Array write, no reset so it maps to block RAM
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (port.wr_en) begin
      array[port.wr_addr] <= port.wr_data;
    end
  end

  // Output register, cleared by either reset
  always_ff @(posedge core_clk or posedge clear) begin
    if (clear) begin
      port.rd_data <= `WORD_RESET;
    end else if (port.rd_en) begin
      port.rd_data <= array[port.rd_addr];
    end
  end
endmodule : fifo_mem

// file: bench/fifo_partner.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Writer and reader clock sources
// ----------------------------------------------------------------
module fifo_partner (
  input wire logic core_clk, // System clock
  input wire logic run_w, // Writer clock runs
  input wire logic run_r, // Reader clock runs
  output logic write_clk, // Writer clock
  output logic read_clk // Reader clock
);
  int w_cnt = 0;
  int r_cnt = 0;

  // Both clocks start parked low
  initial begin
    write_clk = 1'b0;
    read_clk = 1'b0;
  end

  // unrelated periods, four and six cycles
  // A stopped clock parks low, so no stray rising edge appears
  always @(negedge core_clk) begin
    w_cnt <= (w_cnt + 1) % 2;
    r_cnt <= (r_cnt + 1) % 3;
    if (w_cnt == 1) begin
      write_clk <= run_w & ~write_clk;
    end
    if (r_cnt == 2) begin
      read_clk <= run_r & ~read_clk;
    end
  end
endmodule : fifo_partner

// file: bench/fifo_top_chk.sv
`timescale 1ns/100ps
`include "fifo_consts.svh"

// ----------------------------------------------------------------
// Port-level checks of flags and output register
// ----------------------------------------------------------------
module fifo_top_chk (
  input wire logic core_clk, // System clock
  input wire logic reset, // Async reset
  input wire logic write_clk, // Writer clock
  input wire logic read_clk, // Reader clock
  input wire logic flag_timing_select, // Timing mode pin
  input wire logic full_reset_n, // Master reset
  input wire logic partial_reset_n, // Partial reset
  input wire logic output_enable_n, // Output enable
  input wire logic [`FIFO_WIDTH-1:0] data_out, // Read data
  input wire logic data_out_oe_n, // Output drive enable
  input wire logic empty_flag_n, // Empty
  input wire logic full_flag_n, // Full
  input wire logic half_full_flag_n, // Half full
  input wire logic almost_empty_flag_n, // Almost empty
  input wire logic almost_full_flag_n // Almost full
);
  logic sync_mode;
  wire rst_ok = full_reset_n & partial_reset_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Timing mode only counts while master reset is held
  always_ff @(posedge core_clk) begin
    if (!full_reset_n) begin
      sync_mode <= flag_timing_select;
    end
  end

  // Clocks are sampled, so a flag moves the cycle after the edge
  chk_master_clear: assert property (!full_reset_n |->
    !empty_flag_n && !almost_empty_flag_n && full_flag_n && half_full_flag_n
    && almost_full_flag_n && !(|data_out)) else $error("master reset state wrong");
  chk_partial_clear: assert property ($fell(partial_reset_n) |->
    !empty_flag_n && !almost_empty_flag_n && full_flag_n && half_full_flag_n
    && almost_full_flag_n && !(|data_out)) else $error("partial reset state wrong");
  chk_oe_follow: assert property (data_out_oe_n == output_enable_n)
    else $error("output enable not followed");
  chk_full_frozen: assert property (!$rose(write_clk) |=>
    $stable(full_flag_n) || !rst_ok) else $error("full moved without write edge");
  chk_empty_frozen: assert property (!$rose(read_clk) |=>
    $stable(empty_flag_n) || !rst_ok) else $error("empty moved without read edge");
  chk_half_set: assert property ($fell(half_full_flag_n) |->
    $past(write_clk) && !$past(write_clk, 2)) else $error("half full set off write edge");
  chk_half_clear: assert property ($rose(half_full_flag_n) |->
    !rst_ok || ($past(read_clk) && !$past(read_clk, 2)))
    else $error("half full cleared off read edge");
  chk_data_on_read: assert property (!$stable(data_out) |-> !rst_ok
    || ($past(read_clk) && !$past(read_clk, 2))
    || ($past(read_clk, 2) && !$past(read_clk, 3))) else $error("data moved without read");
  chk_sync_almost: assert property (sync_mode && !$rose(write_clk) |=>
    $stable(almost_full_flag_n) || !rst_ok) else $error("almost full moved off write edge");
  chk_ae_fall_read: assert property ($fell(almost_empty_flag_n) |-> !rst_ok
    || ($past(read_clk) && !$past(read_clk, 2)))
    else $error("almost empty set off read edge");
  chk_ae_rise_write: assert property (!sync_mode && $rose(almost_empty_flag_n) |->
    $past(write_clk) && !$past(write_clk, 2))
    else $error("almost empty released off write edge");
endmodule : fifo_top_chk

bind fifo_top fifo_top_chk i_chk (.core_clk, .reset, .write_clk, .read_clk,
  .flag_timing_select, .full_reset_n, .partial_reset_n, .output_enable_n, .data_out,
  .data_out_oe_n, .empty_flag_n, .full_flag_n, .half_full_flag_n, .almost_empty_flag_n,
  .almost_full_flag_n);

// file: bench/dual_clock_fifo_offset_programming_test.sv
`timescale 1ns/100ps
`include "fifo_consts.svh"

`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, e, a); end end

module dual_clock_fifo_offset_programming_test;
  logic core_clk, reset = 1'b1, write_clk, read_clk, run_w = 1'b0, run_r = 1'b0;
  logic write_enable_n = 1'b1, read_enable_n = 1'b1, offset_load_select_n = 1'b1;
  logic serial_load_enable_n = 1'b1, serial_in = 1'b0, flag_timing_select = 1'b1;
  logic full_reset_n = 1'b0, partial_reset_n = 1'b1, output_enable_n = 1'b0;
  fifo_pkg::word_t data_in = 16'h0000, data_out;
  logic data_out_oe_n, empty_flag_n, full_flag_n, half_full_flag_n;
  logic almost_empty_flag_n, almost_full_flag_n;
  int n_mismatch = 0, checks_done = 0;
  wire [4:0] flags = {empty_flag_n, full_flag_n, half_full_flag_n, almost_empty_flag_n,
    almost_full_flag_n};

  fifo_partner i_partner (.core_clk, .run_w, .run_r, .write_clk, .read_clk);
  fifo_top i_dut (.core_clk, .reset, .write_clk, .read_clk, .write_enable_n,
    .read_enable_n, .offset_load_select_n, .serial_load_enable_n, .serial_in,
    .flag_timing_select, .full_reset_n, .partial_reset_n, .output_enable_n, .data_in,
    .data_out, .data_out_oe_n, .empty_flag_n, .full_flag_n, .half_full_flag_n,
    .almost_empty_flag_n, .almost_full_flag_n);

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Fill of the whole array dominates the run time
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end

  function automatic fifo_pkg::word_t dv(input int i);
    return fifo_pkg::word_t'(i) ^ 16'h5a3c;
  endfunction : dv

  // One writer-clock operation, held until its edge is taken
  task automatic wop(input logic [3:0] ctl, input fifo_pkg::word_t d);
    @(negedge core_clk iff write_clk === 1'b0);
    {write_enable_n, offset_load_select_n, serial_load_enable_n, serial_in} = ctl;
    data_in = d;
    @(negedge core_clk iff write_clk === 1'b1);
    {write_enable_n, offset_load_select_n, serial_load_enable_n, serial_in} = 4'he;
  endtask : wop

  // One read, then the output register is compared
  task automatic rop(input fifo_pkg::word_t e);
    @(negedge core_clk iff read_clk === 1'b0);
    read_enable_n = 1'b0;
    @(negedge core_clk iff read_clk === 1'b1);
    read_enable_n = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK("data_out", e, data_out)
  endtask : rop

  // full bit set, legal controls only
  // Pauses mid-way for idle edges and one memory write
  task automatic load(input fifo_pkg::serial_t v, input int brk);
    for (int i = 0; i < 24; i++) begin
      if (i == brk) begin
        wop(4'hb, 16'h0000);
        wop(4'hd, 16'h0000);
        wop(4'h6, dv(0));
      end
      wop({3'b100, v[i]}, 16'h0000);
    end
  endtask : load

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  // master reset first, serial input low
  initial begin
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK("flags", 5'h0d, flags)
    full_reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    run_w = 1'b1;
    run_r = 1'b1;
    load(24'h003002, 10);
    for (int i = 1; i < 4; i++) wop(4'h6, dv(i));
    repeat (40) @(negedge core_clk);
    `CHK("flags", 5'h1f, flags)
    rop(dv(0));
    rop(dv(1));
    repeat (40) @(negedge core_clk);
    `CHK("almost_empty", 1'b0, almost_empty_flag_n)
    rop(dv(2));
    rop(dv(3));
    repeat (40) @(negedge core_clk);
    rop(dv(3));
    `CHK("empty", 1'b0, empty_flag_n)
    $display("test load and stream done");
    run_r = 1'b0;
    for (int i = 0; i < 4096; i++) begin
      wop(4'h6, dv(i + 16));
      if (i inside {2047, 2048, 4091, 4092, 4095})
        `CHK("fill", {i < 4095, i < 2048, i < 4092}, {full_flag_n, half_full_flag_n,
          almost_full_flag_n})
    end
    wop(4'h6, 16'hffff);
    `CHK("full_empty", 2'b00, {full_flag_n, empty_flag_n})
    run_r = 1'b1;
    repeat (40) @(negedge core_clk);
    rop(dv(16));
    repeat (40) @(negedge core_clk);
    `CHK("full", 1'b1, full_flag_n)
    $display("test fill done");
    partial_reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("flags", 5'h0d, flags)
    `CHK("data_out", 16'h0000, data_out)
    partial_reset_n = 1'b1;
    for (int i = 0; i < 3; i++) wop(4'h6, dv(i));
    repeat (40) @(negedge core_clk);
    `CHK("empty_almost", 2'b11, {empty_flag_n, almost_empty_flag_n})
    $display("test partial reset done");
    // Second master reset picks asynchronous almost flags and default offsets
    // Reader parked, so only write edges may release almost-empty
    run_r = 1'b0;
    flag_timing_select = 1'b0;
    full_reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK("flags", 5'h0d, flags)
    full_reset_n = 1'b1;
    flag_timing_select = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 128; i++) begin
      wop(4'h6, dv(i));
      if (i >= 126) begin
        `CHK("empty", 1'b0, empty_flag_n)
        `CHK("almost_empty", i == 127, almost_empty_flag_n)
      end
    end
    run_r = 1'b1;
    repeat (40) @(negedge core_clk);
    rop(dv(0));
    `CHK("almost_empty", 1'b0, almost_empty_flag_n)
    $display("test flag timing done");
    output_enable_n = 1'b1;
    #1 `CHK("oe", 1'b1, data_out_oe_n)
    @(negedge core_clk);
    output_enable_n = 1'b0;
    #1 `CHK("oe", 1'b0, data_out_oe_n)
    $display("test output enable done");
    conclude();
  end
endmodule : dual_clock_fifo_offset_programming_test
